// File: adc_iface_pkg.sv
// Constants shared by the converter host interface: register map, setup-word
// fields, pin vector positions and result format codes.
// Assumes a single 50 MHz clock domain; all pins are synchronised inside the interface.
//
// How it works
// - Pin mode takes settings from pins, a few listed bits from the setup word.
// - Register mode uses setup word only, if bits 29 and 28 are both zero.
// - Interface select low runs parallel bus, high runs serial port.
// - Serial frame starts at the falling edge of frame sync.
// - Serial results go out MSB first, changing on shift clock falls.
// - 12 and 14 bit results sit LSB-aligned in 16 bits, sign-extended.
// - Serial configuration input is captured on shift clock falling edges.
// - First output always on, second by its enable or the upper enable, third and fourth together.
// - Four outputs: each carries its pair channel 0 then channel 1.
// - Two outputs: first carries pairs A then C, second pairs B then D.
// - One output carries A0, A1, B0, B1, C0, C1, D0, D1 in order.
// - Results are two's complement with the listed full-scale codes.
// - Parallel bus upper bits carry sign copies for 12 and 14 bit results.
// - A setup write takes effect only when its top bit is one.
// - Serial frames carry setup updates while results shift out.
// - Setup word values in the listed bits stay in force after returning to pin mode.
// - Master pair trigger restarts parallel readout sequencing at channel A0.
// - Result ready rises on a new result load, falls at next read.
package adc_iface_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_SETUP = 8'h04;
  localparam logic [7:0] OFF_EFFECTIVE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Setup word fields and reset values
  localparam int BIT_UPDATE_ENABLE = 31;
  localparam int BIT_CLOCK_SOURCE = 29;
  localparam int BIT_C28 = 28;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [31:0] PIN_MODE_REG_MASK = 32'h6C54_23FF;
  localparam logic [31:0] PAR_EXTRA_MASK = 32'h0000_4000;
  localparam logic [1:0] CONTROL_RESET = 2'h0;

  // Resolution codes held in the control register
  localparam logic [1:0] RES_16 = 2'h0;
  localparam logic [1:0] RES_14 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;

  // Serial framing
  localparam logic [6:0] SETUP_LAST_BIT = 7'h1F;
  localparam int WORD_BITS = 16;
  localparam int NUM_WORDS = 8;

  // Positions inside the synchronised pin vector
  localparam int PIN_CFG_SRC = 0;
  localparam int PIN_IF_SEL = 1;
  localparam int PIN_FS = 2;
  localparam int PIN_SCLK = 3;
  localparam int PIN_SDI = 4;
  localparam int PIN_SEL_B = 5;
  localparam int PIN_UPPER_PORTS_ENABLE = 6;
  localparam int PIN_TRIG = 7;
  localparam int PIN_CS_N = 8;
  localparam int PIN_RD_N = 9;
  localparam int PIN_WR_N = 10;
  localparam int NUM_PINS = 11;

  // Parallel setup write phase
  typedef enum logic [1:0] {
    PH_HIGH = 2'b01,
    PH_LOW = 2'b10
  } wr_phase_e;

endpackage

// File: adc_host_interface.sv
// Host-facing digital interface of an eight-channel converter: setup word,
// serial and parallel readout, result formatting, AXI4-Lite register access.
// Assumes conversion results arrive on aclk with a one-cycle load pulse; all
// pins come from outside the clock domain and are synchronised here.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module adc_host_interface (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [127:0] conv_results,
  input wire logic conv_load,
  input wire logic config_source_select,
  input wire logic interface_select,
  input wire logic [31:0] pin_config,
  input wire logic frame_sync,
  input wire logic shift_clock,
  input wire logic serial_config_in,
  input wire logic second_port_enable,
  input wire logic upper_ports_enable,
  input wire logic master_pair_trigger,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [15:0] parallel_data_bus_in,
  output logic [15:0] parallel_data_bus_out,
  output logic parallel_data_bus_oe,
  output logic serial_out_first,
  output logic serial_out_second,
  output logic serial_out_third,
  output logic serial_out_fourth,
  output logic result_ready,
  output logic [31:0] effective_config
);
  import adc_iface_pkg::*;

  logic [NUM_PINS-1:0] pin_meta, pin_sync, pin_prev;
  logic [31:0] cfg_meta, cfg_sync;
  logic [15:0] db_meta, db_sync;
  logic fs_fall, sclk_fall, rd_fall, rd_rise, wr_rise, trig_rise;
  logic par_mode;
  logic [31:0] setup_word;
  logic [1:0] resolution;
  logic [15:0] out_word [NUM_WORDS];
  logic [6:0] bit_pos, next_pos;
  logic [31:0] sdi_shift;
  logic [2:0] rd_idx;
  logic [15:0] par_high;
  wr_phase_e wr_phase;
  logic [3:0] next_out, port_on, serial_q;
  logic aw_held, w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic axi_wr_fire;
  logic [31:0] axi_setup_merged;

  // Sign-extend a raw result to 16 bits for the selected resolution
  function automatic logic [15:0] sign_fill(input logic [15:0] raw, input logic [1:0] res);
    logic [15:0] v;
    v = raw;
    case (res)
      RES_14: v = {{2{raw[13]}}, raw[13:0]};
      RES_12: v = {{4{raw[11]}}, raw[11:0]};
      default: v = raw;
    endcase
    return v;
  endfunction

  // Two-stage synchronisers, then one more stage for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pin_meta, pin_sync, pin_prev} <= '0;
      {cfg_meta, cfg_sync, db_meta, db_sync} <= '0;
    end else begin
      pin_meta <= {write_n, read_n, chip_select_n, master_pair_trigger, upper_ports_enable,
                   second_port_enable, serial_config_in, shift_clock, frame_sync,
                   interface_select, config_source_select};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      cfg_meta <= pin_config;
      cfg_sync <= cfg_meta;
      db_meta <= parallel_data_bus_in;
      db_sync <= db_meta;
    end
  end

  assign par_mode = !pin_sync[PIN_IF_SEL];
  // frame starts on frame sync fall
  assign fs_fall = !par_mode && pin_prev[PIN_FS] && !pin_sync[PIN_FS];
  assign sclk_fall = !par_mode && !pin_sync[PIN_FS] && pin_prev[PIN_SCLK] && !pin_sync[PIN_SCLK];
  assign rd_fall = par_mode && !pin_sync[PIN_CS_N] && pin_prev[PIN_RD_N] && !pin_sync[PIN_RD_N];
  assign rd_rise = par_mode && !pin_prev[PIN_RD_N] && pin_sync[PIN_RD_N];
  assign wr_rise = par_mode && !pin_sync[PIN_CS_N] && !pin_prev[PIN_WR_N] && pin_sync[PIN_WR_N];
  assign trig_rise = !pin_prev[PIN_TRIG] && pin_sync[PIN_TRIG];

  // output register loads sign-extended two's complement results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        out_word[i] <= '0;
      end
    end else if (conv_load) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        out_word[i] <= sign_fill(conv_results[127 - i*WORD_BITS -: WORD_BITS], resolution);
      end
    end
  end

  // bit position restarts each frame and keeps counting
  always_comb begin
    next_pos = bit_pos;
    if (fs_fall) begin
      next_pos = '0;
    end else if (sclk_fall) begin
      next_pos = bit_pos + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_pos <= '0;
    end else begin
      bit_pos <= next_pos;
    end
  end

  // port enables from the two select pins
  assign port_on = {{2{pin_sync[PIN_UPPER_PORTS_ENABLE]}}, pin_sync[PIN_SEL_B] | pin_sync[PIN_UPPER_PORTS_ENABLE], 1'b1};

  // Per-port word selection; the pattern wraps so words keep cycling
  for (genvar p = 0; p < 4; p++) begin : g_port
    localparam logic [1:0] PI = 2'(p);
    logic [2:0] idx;
    always_comb begin
      idx = next_pos[6:4];
      if (pin_sync[PIN_UPPER_PORTS_ENABLE]) begin
        // pair channel 0 then channel 1
        idx = {PI, next_pos[4]};
      end else if (pin_sync[PIN_SEL_B]) begin
        // pairs A,C on first and B,D on second
        idx = {next_pos[5], PI[0], next_pos[4]};
      end else begin
        // all eight words on the first output
        idx = next_pos[6:4];
      end
      next_out[p] = port_on[p] & out_word[idx][4'hF - next_pos[3:0]];
    end
  end

  // outputs change at frame start or shift clock fall, or drop low when their port is switched off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_q <= '0;
    end else if (fs_fall || sclk_fall) begin
      serial_q <= next_out;
    end else begin
      // A port switched off goes quiet now rather than at the next frame
      serial_q <= serial_q & port_on;
    end
  end

  assign serial_out_first = serial_q[0];
  assign serial_out_second = serial_q[1];
  assign serial_out_third = serial_q[2];
  assign serial_out_fourth = serial_q[3];

  // capture setup bits while results shift out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdi_shift <= '0;
    end else if (sclk_fall && bit_pos <= SETUP_LAST_BIT) begin
      sdi_shift <= {sdi_shift[30:0], pin_sync[PIN_SDI]};
    end
  end

  // Parallel readout; trigger restarts the word index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_idx <= '0;
      parallel_data_bus_out <= '0;
      parallel_data_bus_oe <= 1'b0;
    end else begin
      if (rd_fall) begin
        // words already carry sign copies in the top bits
        parallel_data_bus_out <= out_word[rd_idx];
        parallel_data_bus_oe <= 1'b1;
      end else if (rd_rise || pin_sync[PIN_CS_N] || !par_mode) begin
        parallel_data_bus_oe <= 1'b0;
      end
      if (trig_rise) begin
        rd_idx <= '0;
      end else if (rd_rise && parallel_data_bus_oe) begin
        rd_idx <= rd_idx + 3'h1;
      end
    end
  end

  // two separately framed 16-bit writes, high half first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_phase <= PH_HIGH;
      par_high <= '0;
    end else if (wr_rise) begin
      case (wr_phase)
        PH_HIGH: begin
          par_high <= db_sync;
          wr_phase <= PH_LOW;
        end
        PH_LOW: wr_phase <= PH_HIGH;
        default: wr_phase <= PH_HIGH;
      endcase
    end
  end

  // AXI write strobes merged onto the current setup word
  always_comb begin
    axi_setup_merged = setup_word;
    for (int b = 0; b < 4; b++) begin
      if (w_strb_q[b]) begin
        axi_setup_merged[b*8 +: 8] = w_data_q[b*8 +: 8];
      end
    end
  end

  assign axi_wr_fire = aw_held && w_held && !s_axi_bvalid;

  // setup word updates only with top bit set and is retained
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_word <= SETUP_RESET;
    end else if (axi_wr_fire && aw_addr_q == OFF_SETUP) begin
      if (axi_setup_merged[BIT_UPDATE_ENABLE]) begin
        setup_word <= axi_setup_merged;
      end
    end else if (sclk_fall && bit_pos == SETUP_LAST_BIT) begin
      // serial word discarded when first bit is zero
      if (sdi_shift[30]) begin
        setup_word <= {sdi_shift[30:0], pin_sync[PIN_SDI]};
      end
    end else if (wr_rise && wr_phase == PH_LOW) begin
      // parallel pair discarded when first bit is zero
      if (par_high[15]) begin
        setup_word <= {par_high, db_sync};
      end
    end
  end

  // effective configuration from pins or setup word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      effective_config <= SETUP_RESET;
    end else if (pin_sync[PIN_CFG_SRC] && !setup_word[BIT_CLOCK_SOURCE]
                 && !setup_word[BIT_C28]) begin
      effective_config <= setup_word;
    end else if (par_mode) begin
      effective_config <= (setup_word & (PIN_MODE_REG_MASK | PAR_EXTRA_MASK))
                          | (cfg_sync & ~(PIN_MODE_REG_MASK | PAR_EXTRA_MASK));
    end else begin
      effective_config <= (setup_word & PIN_MODE_REG_MASK) | (cfg_sync & ~PIN_MODE_REG_MASK);
    end
  end

  // ready on new load, cleared by next read; a load wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ready <= 1'b0;
    end else if (conv_load) begin
      result_ready <= 1'b1;
    end else if (rd_fall || fs_fall) begin
      result_ready <= 1'b0;
    end
  end

  // Control register: result resolution
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resolution <= CONTROL_RESET;
    end else if (axi_wr_fire && aw_addr_q == OFF_CONTROL && w_strb_q[0]) begin
      resolution <= w_data_q[1:0];
    end
  end

  // AXI write channels; address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_held, w_held, s_axi_awready, s_axi_wready, s_axi_bvalid} <= '0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (axi_wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Only control and setup words are writable
        s_axi_bresp <= (aw_addr_q == OFF_CONTROL || aw_addr_q == OFF_SETUP)
                       ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel with one-cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          OFF_CONTROL: s_axi_rdata <= {30'h0, resolution};
          OFF_SETUP: s_axi_rdata <= setup_word;
          OFF_EFFECTIVE: s_axi_rdata <= effective_config;
          OFF_STATUS: s_axi_rdata <= {24'h00_0000, bit_pos[6:5], pin_sync[PIN_UPPER_PORTS_ENABLE],
                                      pin_sync[PIN_SEL_B], result_ready, !pin_sync[PIN_FS],
                                      pin_sync[PIN_IF_SEL], pin_sync[PIN_CFG_SRC]};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // adc_host_interface
`default_nettype wire

// File: adc_host_interface_checker.sv
// Checker: timing relations between the interface ports.
// Assumes a bind onto the top module, with inputs named as its ports.
`timescale 1ns/1ns
`default_nettype none
module adc_host_interface_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic conv_load,
  input wire logic result_ready,
  input wire logic frame_sync,
  input wire logic shift_clock,
  input wire logic interface_select,
  input wire logic second_port_enable,
  input wire logic upper_ports_enable,
  input wire logic parallel_data_bus_oe,
  input wire logic serial_out_first,
  input wire logic serial_out_second,
  input wire logic serial_out_third,
  input wire logic serial_out_fourth
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Bus answers hold until taken and a read answers next cycle; result ready follows loads
  bvalid_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  ready_set_a:
    assert property (conv_load |=> result_ready) else $error("result ready not raised");
  ready_cause_a:
    assert property ($rose(result_ready) |-> $past(conv_load)) else $error("result ready rose alone");
  // Sync lag is three cycles, so four high samples leave the bit settled
  out_steady_a:
    assert property ((shift_clock && !frame_sync)[*4] |-> $stable(serial_out_first))
    else $error("output moved while link clock high");
  second_off_a:
    assert property ((!second_port_enable && !upper_ports_enable)[*5] |-> !serial_out_second)
    else $error("second output active while disabled");
  upper_off_a:
    assert property ((!upper_ports_enable)[*5] |-> !serial_out_third && !serial_out_fourth)
    else $error("upper outputs active while disabled");
  bus_idle_a:
    assert property (interface_select[*5] |-> !parallel_data_bus_oe) else $error("bus driven in serial mode");

  write_seen_c: cover property (s_axi_bvalid && s_axi_bready);
  ready_seen_c: cover property ($rose(result_ready));
  frame_seen_c: cover property ($fell(frame_sync));
endmodule // adc_host_interface_checker

bind adc_host_interface adc_host_interface_checker u_checker (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .conv_load, .result_ready, .frame_sync,
  .shift_clock, .interface_select, .second_port_enable, .upper_ports_enable,
  .parallel_data_bus_oe, .serial_out_first, .serial_out_second, .serial_out_third,
  .serial_out_fourth
);
`default_nettype wire

// File: serial_host.sv
// Serial host model: frames the link and captures all four data outputs.
// Assumes the device shifts on link clock falls; the clock stands low between frames.
`timescale 1ns/1ns
`default_nettype none
module serial_host (
  output logic frame_sync,
  output logic shift_clock,
  output logic serial_config_in,
  input wire logic [3:0] sdo
);
  logic [127:0] cap [4];

  // Idle link: frame inactive, clock still, config line low
  initial begin
    frame_sync = 1'b1;
    shift_clock = 1'b0;
    serial_config_in = 1'b0;
  end

  // One 128-bit transfer; the odd start offset keeps it out of phase with aclk
  task automatic run_frame(input logic [31:0] cfg);
    #7 frame_sync = 1'b0;
    for (int k = 0; k < 128; k++) begin
      #80 shift_clock = 1'b1;
      for (int p = 0; p < 4; p++) cap[p][127 - k] = sdo[p];
      serial_config_in = (k < 32) ? cfg[31 - k] : 1'b0;
      #80 shift_clock = 1'b0;
    end
    #80 frame_sync = 1'b1;
  endtask
endmodule // serial_host
`default_nettype wire

// File: adc_host_interface_tb.sv
// Testbench: register access, serial frames in every port mode, parallel readout.
// Assumes the serial host model owns the link pins; aclk runs at 50 MHz.
`timescale 1ns/1ns
`default_nettype none
module adc_host_interface_tb;
  import adc_iface_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic conv_load, config_source_select, interface_select, frame_sync, shift_clock;
  logic serial_config_in, second_port_enable, upper_ports_enable, master_pair_trigger;
  logic chip_select_n, read_n, write_n, parallel_data_bus_oe, result_ready;
  logic serial_out_first, serial_out_second, serial_out_third, serial_out_fourth;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] parallel_data_bus_in, parallel_data_bus_out;
  logic [15:0] ex [8];
  logic [31:0] s_axi_wdata, s_axi_rdata, pin_config, effective_config, rd, cfg, setup;
  logic [127:0] conv_results, ev;
  int n_fail, checks, w, s;

  adc_host_interface u_adc_host_interface (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .conv_results, .conv_load, .config_source_select,
    .interface_select, .pin_config, .frame_sync, .shift_clock, .serial_config_in,
    .second_port_enable, .upper_ports_enable, .master_pair_trigger, .chip_select_n,
    .read_n, .write_n, .parallel_data_bus_in, .parallel_data_bus_out,
    .parallel_data_bus_oe, .serial_out_first, .serial_out_second, .serial_out_third,
    .serial_out_fourth, .result_ready, .effective_config
  );
  serial_host u_serial_host (
    .frame_sync, .shift_clock, .serial_config_in,
    .sdo({serial_out_fourth, serial_out_third, serial_out_second, serial_out_first})
  );

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // one setup half, framed by its own chip select
  task automatic pwr(input logic [15:0] d);
    chip_select_n <= 1'b0;
    parallel_data_bus_in <= d;
    write_n <= 1'b0;
    repeat (4) @(posedge aclk);
    write_n <= 1'b1;
    repeat (4) @(posedge aclk);
    chip_select_n <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask

  // New results; words 0 and 1 hold the negative and positive full-scale codes
  task automatic load(input int r);
    w = 16 - 2 * r;
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? (1 << (w - 1)) : (i == 1) ? ((1 << (w - 1)) - 1) : $urandom;
      s = (s << (32 - w)) >>> (32 - w);
      ex[i] = s[15:0];
      ev[127 - 16 * i -: 16] = ex[i] & 16'((1 << w) - 1);
    end
    conv_results <= ev;
    conv_load <= 1'b1;
    @(posedge aclk);
    conv_load <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic complete_run();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {conv_load, config_source_select, interface_select, master_pair_trigger} = '0;
    {second_port_enable, upper_ports_enable, chip_select_n, read_n, write_n} = 5'h07;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, conv_results} = '0;
    s_axi_wstrb = 4'hF;
    parallel_data_bus_in = 16'h0000;
    {n_fail, checks} = '0;
    setup = 32'h0000_0000;
    void'($urandom(18869));
    pin_config = $urandom;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(OFF_CONTROL);
    chk(rd, 32'(CONTROL_RESET));
    axr(8'h10);
    chk(rd | 32'(rsp), 32'(RESP_SLVERR));
    axw(OFF_EFFECTIVE, 32'hFFFF_FFFF);
    chk(32'(rsp), 32'(RESP_SLVERR));
    $display("test registers done");
    // Every resolution in every port mode; only two-port frames carry an update
    interface_select <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      for (int m = 0; m < 3; m++) begin
        second_port_enable <= (m == 1);
        upper_ports_enable <= (m == 2);
        axw(OFF_CONTROL, 32'(r));
        load(r);
        chk(32'(result_ready), 32'h1);
        cfg = {m == 1, 3'h0, 28'($urandom)};
        u_serial_host.run_frame(cfg);
        if (cfg[31]) setup = cfg;
        for (int p = 0; p < 4; p++) begin
          for (int k = 0; k < 128; k++) begin
            s = (k / 16) % (8 >> m);
            s = (m == 0) ? s : 2 * p + (s & 1) + 4 * (s >> 1);
            ev[127 - k] = (p == 0 || (p == 1 && m > 0) || m == 2) ? ex[s][15 - k % 16] : 1'b0;
          end
          for (int j = 0; j < 4; j++) chk(u_serial_host.cap[p][32 * j +: 32], ev[32 * j +: 32]);
        end
        @(posedge aclk);
        chk(32'(result_ready), 32'h0);
        axr(OFF_SETUP);
        chk(rd, setup);
        axr(OFF_EFFECTIVE);
        chk(rd, (setup & PIN_MODE_REG_MASK) | (pin_config & ~PIN_MODE_REG_MASK));
        axr(OFF_STATUS);
        chk(rd, 32'({m == 2, m == 1, 4'h2}));
        $display("test serial r=%0d m=%0d done", r, m);
      end
    end
    // Register mode, a refused write, then back to pin mode
    config_source_select <= 1'b1;
    interface_select <= 1'b0;
    cfg = {4'h8, 28'($urandom)};
    axw(OFF_SETUP, cfg);
    axw(OFF_SETUP, {1'b0, ~cfg[30:0]});
    axr(OFF_EFFECTIVE);
    chk(rd, cfg);
    config_source_select <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(effective_config, (cfg & 32'h6C54_63FF) | (pin_config & ~32'h6C54_63FF));
    $display("test modes done");
    // Parallel reads, sequence restarted by the master trigger after three words
    load(2);
    chip_select_n <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      if (i == 3) begin
        master_pair_trigger <= 1'b1;
        repeat (4) @(posedge aclk);
        master_pair_trigger <= 1'b0;
      end
      s = (i < 3) ? i : i - 3;
      read_n <= 1'b0;
      repeat (5) @(posedge aclk);
      chk({15'h0, parallel_data_bus_oe, parallel_data_bus_out}, {16'h0001, ex[s]});
      read_n <= 1'b1;
      repeat (5) @(posedge aclk);
    end
    chk(32'(result_ready), 32'h0);
    $display("test parallel done");
    // Register mode setup through two framed bus writes, then a refused pair
    chip_select_n <= 1'b1;
    config_source_select <= 1'b1;
    cfg = {4'h8, 28'($urandom)};
    repeat (4) @(posedge aclk);
    pwr(cfg[31:16]);
    pwr(cfg[15:0]);
    pwr(~cfg[31:16]);
    pwr(~cfg[15:0]);
    axr(OFF_SETUP);
    chk(rd, cfg);
    axr(OFF_EFFECTIVE);
    chk(rd, cfg);
    $display("test parallel setup done");
    complete_run();
  end

  // Watchdog: the whole run needs well under half a millisecond
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end
endmodule // adc_host_interface_tb
`default_nettype wire
